/* bench/afe_spi_command_decoder_tb.sv */
`timescale 1ns/1ps
module afe_spi_command_decoder_tb
	import afe_spi_pkg::*;
();
	//------------------------------------------------
	// Signals
	//------------------------------------------------
	logic clock, resetn, cs_n, sclk, alert_out, alert_oe, data_in, data_out, data_oe;
	logic demod_in, carrier_in, device_active, agc_init_pulse, agc_settling, flt;
	logic [8:1] status_in;
	logic [7:0] agc_level, agc_slice_level;
	logic agc_fast_track, sleep_mode, soft_reset, strength_enable, strength_pulldown_enable;
	logic [2:0] clamp_on;
	logic h_clk_oe, h_clk, h_doe, h_d;
	logic [15:0] rx;
	int err_count = 0;
	int n_checks = 0;
	int sr_cnt = 0;
	int cyc = 0;
	localparam int CYC_MAX = 20000;

	// Wire levels: host drive, else device, else pull-up or toggling float
	assign sclk = h_clk_oe ? h_clk : (alert_oe ? alert_out : 1'b1);
	assign data_in = h_doe ? h_d : (data_oe ? data_out : flt);

	//------------------------------------------------
	// Instances
	//------------------------------------------------
	afe_spi_command_decoder #(.AGC_W(8)) u_afe_spi_command_decoder (
		.clock(clock), .resetn(resetn), .cs_n(cs_n), .sclk(sclk),
		.alert_out(alert_out), .alert_oe(alert_oe), .data_in(data_in),
		.data_out(data_out), .data_oe(data_oe), .demod_in(demod_in),
		.carrier_in(carrier_in), .status_in(status_in), .device_active(device_active),
		.agc_init_pulse(agc_init_pulse), .agc_settling(agc_settling),
		.agc_level(agc_level), .agc_slice_level(agc_slice_level),
		.agc_fast_track(agc_fast_track), .clamp_on(clamp_on), .sleep_mode(sleep_mode),
		.soft_reset(soft_reset), .strength_enable(strength_enable),
		.strength_pulldown_enable(strength_pulldown_enable)
	);
	ascd_host u_ascd_host (
		.cs_n(cs_n), .clk_oe(h_clk_oe), .clk_lvl(h_clk),
		.d_oe(h_doe), .d_out(h_d), .data_wire(data_in)
	);

	//------------------------------------------------
	// Clock, float pattern, ceiling
	//------------------------------------------------
	// Core clock, 8 ns period
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	// Released data line changes every cycle
	always @(posedge clock) flt <= (flt !== 1'b1);
	// Cycle ceiling and soft reset pulse count
	always @(posedge clock) begin
		cyc++;
		if (soft_reset === 1'b1) begin
			sr_cnt++;
		end
		if (cyc == CYC_MAX) begin
			err_count++;
			report_and_stop();
		end
	end

	//------------------------------------------------
	// Shared tasks
	//------------------------------------------------
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk_port(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_read(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic [8:0] par(input logic [7:0] d);
		return {d, ~^d};
	endfunction
	task automatic idle(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic send(input afe_frame_s f, input int n, input logic rd);
		@(negedge clock);
		#3;
		u_ascd_host.xfer(f, n, rd, rx);
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [8:0] exp);
		send('{CMD_READ, a, 9'h000}, 16, 1'b0);
		send('{3'h0, 4'h0, 9'h000}, 16, 1'b1);
		chk_read("read data", {7'h00, exp}, rx);
	endtask
	task automatic pulse();
		@(negedge clock);
		agc_init_pulse = 1'b1;
		@(negedge clock);
		agc_init_pulse = 1'b0;
	endtask

	//------------------------------------------------
	// Scenarios
	//------------------------------------------------
	// Reset state and every address read
	task automatic t_reset();
		chk_port("alert enable", 8'h01, {7'h00, alert_oe});
		chk_port("alert level", 8'h00, {7'h00, alert_out});
		chk_port("data enable", 8'h01, {7'h00, data_oe});
		chk_port("clamp", 8'h00, {5'h00, clamp_on});
		for (int a = 0; a < REG_COUNT; a++) begin
			rd_chk(a[3:0], (a == 7) ? {status_in, 1'b1} : CFG_RESET);
		end
	endtask
	// Write, read back, parity, read-only status
	task automatic t_regs();
		logic [7:0] v [7];
		v = '{8'h02, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h7d};
		for (int a = 0; a < 7; a++) begin
			send('{CMD_WRITE, a[3:0], par(v[a])}, 16, 1'b0);
		end
		for (int a = 0; a < 7; a++) begin
			rd_chk(a[3:0], par(v[a]));
		end
		chk_port("alert enable", 8'h00, {7'h00, alert_oe});
		send('{CMD_WRITE, ADDR_XY_SENSITIVITY, 9'h003}, 16, 1'b0);
		chk_port("alert enable", 8'h01, {7'h00, alert_oe});
		send('{CMD_WRITE, ADDR_XY_SENSITIVITY, par(8'h00)}, 16, 1'b0);
		send('{CMD_WRITE, ADDR_DEVICE_STATUS, 9'h1fe}, 16, 1'b0);
		rd_chk(ADDR_DEVICE_STATUS, {status_in, 1'b0});
	endtask
	// Command-only frames, aborts, soft reset gating
	task automatic t_cmds();
		int s0;
		s0 = sr_cnt;
		send('{CMD_CLAMP_ON, 4'h9, 9'h1ff}, 16, 1'b0);
		chk_port("clamp", 8'h05, {5'h00, clamp_on});
		send('{CMD_SLEEP, 4'h0, 9'h000}, 16, 1'b0);
		chk_port("sleep", 8'h01, {7'h00, sleep_mode});
		send('{CMD_CLAMP_OFF, 4'h0, 9'h000}, 15, 1'b0);
		chk_port("clamp", 8'h05, {5'h00, clamp_on});
		send('{CMD_CLAMP_OFF, 4'h0, 9'h000}, 16, 1'b0);
		chk_port("sleep", 8'h00, {7'h00, sleep_mode});
		chk_port("clamp", 8'h00, {5'h00, clamp_on});
		send('{CMD_CLAMP_ON, 4'h0, 9'h000}, 32, 1'b0);
		chk_port("clamp", 8'h05, {5'h00, clamp_on});
		send('{CMD_SOFT_RESET, 4'h0, 9'h000}, 16, 1'b0);
		chk_port("soft reset pulses", 8'h01, 8'(sr_cnt - s0));
		chk_port("clamp", 8'h05, {5'h00, clamp_on});
		@(negedge clock);
		device_active = 1'b0;
		send('{CMD_SOFT_RESET, 4'h0, 9'h000}, 16, 1'b0);
		chk_port("soft reset pulses", 8'h01, 8'(sr_cnt - s0));
		@(negedge clock);
		device_active = 1'b1;
	endtask
	// Held AGC level, soft reset clear, tracking return
	task automatic t_agc();
		@(negedge clock);
		agc_level = 8'h5a;
		agc_settling = 1'b1;
		send('{CMD_AGC_KEEP_ON, 4'h0, 9'h000}, 16, 1'b0);
		pulse();
		agc_level = 8'h33;
		idle(3);
		chk_port("slice level", 8'h5a, agc_slice_level);
		chk_port("fast track", 8'h00, {7'h00, agc_fast_track});
		send('{CMD_SOFT_RESET, 4'h0, 9'h000}, 16, 1'b0);
		chk_port("slice level", 8'h33, agc_slice_level);
		pulse();
		agc_level = 8'h11;
		idle(3);
		chk_port("slice level", 8'h33, agc_slice_level);
		send('{CMD_AGC_KEEP_OFF, 4'h0, 9'h000}, 16, 1'b0);
		chk_port("slice level", 8'h11, agc_slice_level);
		chk_port("fast track", 8'h01, {7'h00, agc_fast_track});
	endtask
	// Output type routing, pull-down, strength suspend
	task automatic t_out();
		@(negedge clock);
		carrier_in = 1'b1;
		send('{CMD_WRITE, ADDR_X_TUNING_OUTPUT_TYPE, par(8'h40)}, 16, 1'b0);
		chk_port("data pin", 8'h01, {7'h00, data_out});
		@(negedge clock);
		carrier_in = 1'b0;
		idle(8);
		chk_port("data pin", 8'h00, {7'h00, data_out});
		chk_port("pulldown", 8'h00, {7'h00, strength_pulldown_enable});
		send('{CMD_WRITE, ADDR_X_TUNING_OUTPUT_TYPE, par(8'hc0)}, 16, 1'b0);
		chk_port("strength", 8'h01, {7'h00, strength_enable});
		send('{CMD_WRITE, ADDR_X_TUNING_OUTPUT_TYPE, par(8'h80)}, 16, 1'b0);
		chk_port("data enable", 8'h00, {7'h00, data_oe});
		chk_port("pulldown", 8'h01, {7'h00, strength_pulldown_enable});
		fork
			send('{CMD_AGC_KEEP_OFF, 4'h0, 9'h000}, 16, 1'b0);
			begin
				#400;
				chk_port("strength", 8'h00, {7'h00, strength_enable});
			end
		join
		chk_port("strength", 8'h01, {7'h00, strength_enable});
		@(negedge clock);
		demod_in = 1'b1;
		send('{CMD_WRITE, ADDR_X_TUNING_OUTPUT_TYPE, par(8'h00)}, 16, 1'b0);
		chk_port("data pin", 8'h01, {7'h00, data_out});
		chk_port("pulldown", 8'h00, {7'h00, strength_pulldown_enable});
		chk_port("strength", 8'h00, {7'h00, strength_enable});
	endtask

	//------------------------------------------------
	// Main sequence
	//------------------------------------------------
	initial begin
		resetn = 1'b0;
		demod_in = 1'b0;
		carrier_in = 1'b0;
		status_in = 8'ha5;
		device_active = 1'b1;
		agc_init_pulse = 1'b0;
		agc_settling = 1'b0;
		agc_level = 8'h00;
		repeat (3) @(negedge clock);
		resetn = 1'b1;
		idle(8);
		t_reset();
		t_regs();
		t_cmds();
		t_agc();
		t_out();
		report_and_stop();
	end
endmodule

/* bench/ascd_host.sv */
`timescale 1ns/1ps
module ascd_host (
	// Select and clock drive
	output logic cs_n,
	output logic clk_oe,
	output logic clk_lvl,
	// Data line drive and sense
	output logic d_oe,
	output logic d_out,
	input wire logic data_wire
);
	//------------------------------------------------
	// Idle pin state
	//------------------------------------------------
	// Select high, both lines released
	initial begin
		cs_n = 1'b1;
		clk_oe = 1'b0;
		clk_lvl = 1'b0;
		d_oe = 1'b0;
		d_out = 1'b0;
	end

	//------------------------------------------------
	// One select-low burst
	//------------------------------------------------
	// alert held low, any clock count
	task automatic xfer(input logic [15:0] tx, input int nclk, input logic rd,
		output logic [15:0] rx);
		rx = 16'h0000;
		clk_oe = 1'b1;
		clk_lvl = 1'b0;
		#24;
		cs_n = 1'b0;
		d_oe = !rd;
		#48;
		for (int i = 0; i < nclk; i++) begin
			d_out = tx[15 - (i % 16)];
			#24;
			clk_lvl = 1'b1;
			rx = {rx[14:0], data_wire};
			#24;
			clk_lvl = 1'b0;
		end
		#24;
		d_oe = 1'b0;
		cs_n = 1'b1;
		#24;
		clk_oe = 1'b0;
		#80;
	endtask
endmodule

/* rtl/afe_spi_command_decoder.sv */
`timescale 1ns/1ps
module afe_spi_command_decoder
	import afe_spi_pkg::*;
#(
	parameter int AGC_W = 8
) (
	// Core clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Serial link pins
	input wire logic cs_n,
	input wire logic sclk,
	output logic alert_out,
	output logic alert_oe,
	input wire logic data_in,
	output logic data_out,
	output logic data_oe,
	// Analog side digital sources
	input wire logic demod_in,
	input wire logic carrier_in,
	input wire logic [8:1] status_in,
	input wire logic device_active,
	// AGC interface
	input wire logic agc_init_pulse,
	input wire logic agc_settling,
	input wire logic [AGC_W-1:0] agc_level,
	output logic [AGC_W-1:0] agc_slice_level,
	output logic agc_fast_track,
	// Control outputs
	output logic [2:0] clamp_on,
	output logic sleep_mode,
	output logic soft_reset,
	output logic strength_enable,
	output logic strength_pulldown_enable
);
	// Assertion clock and reset
	default clocking core_cb @(posedge clock); endclocking
	default disable iff (!resetn);

	//------------------------------------------------------------
	// Link domain
	//------------------------------------------------------------
	logic link_rst_n;
	logic [3:0] in_cnt_reg;
	logic [14:0] shift_reg;
	logic bit_tgl_reg, frame_tgl_reg;
	afe_frame_s frame_hold_reg;
	logic [3:0] out_cnt_reg;
	logic out_bit_reg;
	logic [15:0] read_word_reg;
	logic read_pending_reg;
	logic data_out_main_reg, data_oe_main_reg;

	// Link bit counters and shift registers are held clear while select is high
	assign link_rst_n = resetn & ~cs_n;

	always_ff @(posedge sclk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			in_cnt_reg <= 4'h0;
			shift_reg <= 15'h0000;
		end else begin
			in_cnt_reg <= in_cnt_reg + 4'h1;
			shift_reg <= {shift_reg[13:0], data_in};
		end
	end

	always_ff @(posedge sclk or negedge resetn) begin
		if (!resetn) begin
			bit_tgl_reg <= 1'b0;
			frame_tgl_reg <= 1'b0;
			frame_hold_reg <= '0;
		end else if (!cs_n) begin
			bit_tgl_reg <= ~bit_tgl_reg;
			if (in_cnt_reg == 4'hf) begin
				frame_hold_reg <= {shift_reg, data_in};
				frame_tgl_reg <= ~frame_tgl_reg;
			end
		end
	end

	always_ff @(negedge sclk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			out_cnt_reg <= 4'h0;
			out_bit_reg <= 1'b0;
		end else begin
			out_cnt_reg <= out_cnt_reg + 4'h1;
			out_bit_reg <= read_word_reg[4'hd - out_cnt_reg + 4'h1];
		end
	end

	assign data_out = cs_n ? data_out_main_reg : out_bit_reg;
	assign data_oe = cs_n ? data_oe_main_reg : read_pending_reg;

	//------------------------------------------------------------
	// Input synchronisers
	//------------------------------------------------------------
	localparam int SYNC_N = 5;
	logic [SYNC_N-1:0] sync_raw;
	logic [SYNC_N-1:0] sync1_reg, sync2_reg, sync3_reg, sync_q_reg;

	assign sync_raw = {cs_n, demod_in, carrier_in, bit_tgl_reg, frame_tgl_reg};

	// Three stages, change taken once stages two and three agree
	generate
		for (genvar i = 0; i < SYNC_N; i++) begin : g_sync
			always_ff @(posedge clock or negedge resetn) begin
				if (!resetn) begin
					sync1_reg[i] <= (i == SYNC_N - 1);
					sync2_reg[i] <= (i == SYNC_N - 1);
					sync3_reg[i] <= (i == SYNC_N - 1);
					sync_q_reg[i] <= (i == SYNC_N - 1);
				end else begin
					sync1_reg[i] <= sync_raw[i];
					sync2_reg[i] <= sync1_reg[i];
					sync3_reg[i] <= sync2_reg[i];
					if (sync2_reg[i] == sync3_reg[i]) begin
						sync_q_reg[i] <= sync3_reg[i];
					end
				end
			end
		end
	endgenerate

	logic cs_high, demod_s, carrier_s, bit_tgl_s, frame_tgl_s;
	assign {cs_high, demod_s, carrier_s, bit_tgl_s, frame_tgl_s} = sync_q_reg;

	//------------------------------------------------------------
	// Frame tracking
	//------------------------------------------------------------
	logic cs_high_d_reg, bit_tgl_d_reg, frame_tgl_d_reg;
	logic [3:0] bit_cnt_reg;
	logic pend_valid_reg;
	afe_frame_s pend_reg;
	logic cs_rise, bit_seen, aligned, cmd_exec;

	assign cs_rise = cs_high & ~cs_high_d_reg;
	assign bit_seen = bit_tgl_s ^ bit_tgl_d_reg;
	assign aligned = (bit_cnt_reg == 4'h0) & ~bit_seen;
	// execute only whole frames; read result frame never executes
	assign cmd_exec = cs_rise & aligned & pend_valid_reg & ~read_pending_reg;

	// Edge history
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cs_high_d_reg <= 1'b1;
			bit_tgl_d_reg <= 1'b0;
			frame_tgl_d_reg <= 1'b0;
		end else begin
			cs_high_d_reg <= cs_high;
			bit_tgl_d_reg <= bit_tgl_s;
			frame_tgl_d_reg <= frame_tgl_s;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			bit_cnt_reg <= 4'h0;
		end else if (cs_rise) begin
			bit_cnt_reg <= 4'h0;
		end else if (bit_seen) begin
			bit_cnt_reg <= bit_cnt_reg + 4'h1;
		end
	end

	// latest complete frame awaits select rise
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pend_valid_reg <= 1'b0;
			pend_reg <= '0;
		end else if (frame_tgl_s != frame_tgl_d_reg) begin
			pend_valid_reg <= 1'b1;
			pend_reg <= frame_hold_reg;
		end else if (cs_rise) begin
			pend_valid_reg <= 1'b0;
		end
	end

	//------------------------------------------------------------
	// Register file
	//------------------------------------------------------------
	logic [8:0] cfg_reg [0:REG_COUNT-2];
	logic [REG_COUNT-2:0] row_ok;
	logic [8:1] col_ok;
	logic parity_err;

	generate
		for (genvar r = 0; r < REG_COUNT - 1; r++) begin : g_cfg
			always_ff @(posedge clock or negedge resetn) begin
				if (!resetn) begin
					cfg_reg[r] <= CFG_RESET;
				end else if (cmd_exec && pend_reg.cmd == CMD_WRITE && pend_reg.addr == 4'(r)) begin
					cfg_reg[r] <= pend_reg.data;
				end
			end
			assign row_ok[r] = ^cfg_reg[r];
		end
		for (genvar b = 1; b < DATA_W; b++) begin : g_col
			logic [REG_COUNT-2:0] column;
			for (genvar r = 0; r < REG_COUNT - 1; r++) begin : g_bit
				assign column[r] = cfg_reg[r][b];
			end
			assign col_ok[b] = ^column;
		end
	endgenerate

	assign parity_err = ~(&row_ok) | ~(&col_ok);

	logic [8:0] rd_value;
	// read mux, status built from status_in and own parity check
	always_comb begin
		rd_value = 9'h000;
		if (pend_reg.addr == ADDR_DEVICE_STATUS) begin
			rd_value = {status_in, parity_err};
		end else if (pend_reg.addr < ADDR_DEVICE_STATUS) begin
			rd_value = cfg_reg[pend_reg.addr[2:0]];
		end
	end

	// read result armed for next burst
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			read_pending_reg <= 1'b0;
			read_word_reg <= 16'h0000;
		end else if (cmd_exec && pend_reg.cmd == CMD_READ) begin
			read_pending_reg <= 1'b1;
			read_word_reg <= {{DUMMY_BITS{1'b0}}, rd_value};
		end else if (cs_rise) begin
			read_pending_reg <= 1'b0;
		end
	end

	//------------------------------------------------------------
	// Command actions
	//------------------------------------------------------------
	logic is_cmd;
	// command-only codes ignore address and data
	assign is_cmd = cmd_exec & (pend_reg.cmd != CMD_READ) & (pend_reg.cmd != CMD_WRITE);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			clamp_on <= 3'h0;
		end else if (is_cmd && pend_reg.cmd == CMD_CLAMP_ON) begin
			clamp_on <= ~cfg_reg[0][CH_DISABLE_LSB +: 3];
		end else if (is_cmd && pend_reg.cmd == CMD_CLAMP_OFF) begin
			clamp_on <= 3'h0;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sleep_mode <= 1'b0;
		end else if (cmd_exec) begin
			sleep_mode <= is_cmd && pend_reg.cmd == CMD_SLEEP;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			soft_reset <= 1'b0;
		end else begin
			soft_reset <= is_cmd && pend_reg.cmd == CMD_SOFT_RESET && device_active;
		end
	end

	logic agc_keep_reg, agc_held_valid_reg;
	logic [AGC_W-1:0] agc_held_reg;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			agc_keep_reg <= 1'b0;
		end else if (is_cmd && pend_reg.cmd == CMD_AGC_KEEP_ON) begin
			agc_keep_reg <= 1'b1;
		end else if (is_cmd && pend_reg.cmd == CMD_AGC_KEEP_OFF) begin
			agc_keep_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			agc_held_valid_reg <= 1'b0;
			agc_held_reg <= '0;
		end else if (agc_keep_reg && agc_init_pulse) begin
			agc_held_valid_reg <= 1'b1;
			agc_held_reg <= agc_level;
		end else if (soft_reset) begin
			agc_held_valid_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			agc_slice_level <= '0;
			agc_fast_track <= 1'b0;
		end else begin
			agc_slice_level <= (agc_keep_reg && agc_held_valid_reg) ? agc_held_reg : agc_level;
			agc_fast_track <= agc_settling & ~(agc_keep_reg & agc_held_valid_reg);
		end
	end

	//------------------------------------------------------------
	// Output selection and alert
	//------------------------------------------------------------
	logic [1:0] out_type;
	logic strength_sel;
	assign out_type = cfg_reg[1][OUTPUT_TYPE_MSB:OUTPUT_TYPE_LSB];
	assign strength_sel = out_type[1];

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			data_out_main_reg <= 1'b0;
			data_oe_main_reg <= 1'b0;
			strength_enable <= 1'b0;
			strength_pulldown_enable <= 1'b0;
		end else begin
			data_out_main_reg <= (out_type == OUT_CARRIER) ? carrier_s : demod_s;
			data_oe_main_reg <= ~strength_sel;
			strength_enable <= strength_sel & cs_high;
			strength_pulldown_enable <= strength_sel & cfg_reg[2][PULLDOWN_BIT];
		end
	end

	// open-collector alert, released while select low
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			alert_out <= 1'b0;
			alert_oe <= 1'b0;
		end else begin
			alert_out <= 1'b0;
			alert_oe <= cs_high & parity_err;
		end
	end

	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------
	property p_write_store;
		cmd_exec && pend_reg.cmd == CMD_WRITE && pend_reg.addr == ADDR_Y_TUNING
		|=> cfg_reg[2] == $past(pend_reg.data);
	endproperty
	a_write_store: assert property (p_write_store) else $error("write not stored");
	property p_status_ro;
		cmd_exec && pend_reg.cmd == CMD_WRITE && pend_reg.addr == ADDR_DEVICE_STATUS
		|=> $stable(cfg_reg[6]) && $stable(cfg_reg[0]);
	endproperty
	a_status_ro: assert property (p_status_ro) else $error("status write changed state");
	property p_abort;
		cs_rise && bit_cnt_reg != 4'h0 |-> !cmd_exec ##1 $stable(clamp_on);
	endproperty
	a_abort: assert property (p_abort) else $error("partial frame executed");
	property p_clamp_on;
		is_cmd && pend_reg.cmd == CMD_CLAMP_ON |=> clamp_on == ~$past(cfg_reg[0][3:1]);
	endproperty
	a_clamp_on: assert property (p_clamp_on) else $error("clamp on mismatch");
	property p_clamp_off;
		is_cmd && pend_reg.cmd == CMD_CLAMP_OFF |=> clamp_on == 3'h0;
	endproperty
	a_clamp_off: assert property (p_clamp_off) else $error("clamp not released");
	property p_wake;
		cmd_exec && pend_reg.cmd != CMD_SLEEP |=> !sleep_mode;
	endproperty
	a_wake: assert property (p_wake) else $error("command did not wake");
	property p_soft_gate;
		soft_reset |-> $past(device_active) && $past(is_cmd) ##1 !soft_reset;
	endproperty
	a_soft_gate: assert property (p_soft_gate) else $error("soft reset misfired");
	property p_soft_clamp;
		soft_reset |-> $stable(clamp_on);
	endproperty
	a_soft_clamp: assert property (p_soft_clamp) else $error("soft reset dropped clamp");
	property p_pulldown;
		strength_pulldown_enable |-> $past(out_type[1]) && !data_oe_main_reg;
	endproperty
	a_pulldown: assert property (p_pulldown) else $error("pulldown outside strength mode");
	property p_suspend;
		!cs_high |=> !strength_enable;
	endproperty
	a_suspend: assert property (p_suspend) else $error("strength output not suspended");

	c_write: cover property (@(posedge clock) cmd_exec && pend_reg.cmd == CMD_WRITE);
	c_read: cover property (@(posedge clock) read_pending_reg ##[1:400] cs_rise);
	c_abort: cover property (@(posedge clock) cs_rise && bit_cnt_reg != 4'h0);
	c_sleep: cover property (@(posedge clock) sleep_mode ##1 !sleep_mode);

endmodule

/* rtl/afe_spi_pkg.sv */
//------------------------------------------------------------
// Function
// - Output-type 00 demodulator, 01 carrier clock, 10 and 11 signal strength.
// - Pull-down discharge bit acts only while signal-strength output is selected.
// - Clock/alert pin is open-collector alert when select high, clock when low.
// - Data pin drives output when select high, released for signal strength; serial input, or output on reads.
// - Second read frame returns seven dummy bits, eight data bits, parity bit.
// - Select-high gap counts as one clock; data appears at seventh clock after.
// - Frame is command, address, data byte, row parity, most significant first.
// - Mode 0,0: clock idles low, sample on rise, shift out on fall.
// - Clocks per select-low burst must be multiple of sixteen or abort.
// - Codes 000 to 101 ignore address and data but need full frame.
// - Code 110 reads, 111 writes addressed register; 6 column parity, 7 status.
// - Writes to the status register at address 7 change nothing.
// - Parity bit makes each nine-bit configuration value odd.
// - Clamp on drives modulation transistors of enabled channels only.
// - Clamp off releases modulation transistors of every channel.
// - Sleep enters lowest current; any other command wakes.
// - Soft reset during clamp-on keeps the clamp on.
// - Soft reset acts only in active mode, otherwise ignored.
// - Preserve on holds AGC level per initialisation; soft reset clears it.
// - Preserve off returns to fast then slow AGC tracking.
// - Signal-strength output suspended during transfer, resumed after select rises.
//------------------------------------------------------------
package afe_spi_pkg;

	// Frame layout
	localparam int FRAME_BITS = 16;
	localparam int DATA_W = 9;
	localparam int REG_COUNT = 8;

	typedef struct packed {
		logic [2:0] cmd;
		logic [3:0] addr;
		logic [8:0] data;
	} afe_frame_s;

	// Command codes
	localparam logic [2:0] CMD_CLAMP_ON = 3'h0;
	localparam logic [2:0] CMD_CLAMP_OFF = 3'h1;
	localparam logic [2:0] CMD_SLEEP = 3'h2;
	localparam logic [2:0] CMD_AGC_KEEP_ON = 3'h3;
	localparam logic [2:0] CMD_AGC_KEEP_OFF = 3'h4;
	localparam logic [2:0] CMD_SOFT_RESET = 3'h5;
	localparam logic [2:0] CMD_READ = 3'h6;
	localparam logic [2:0] CMD_WRITE = 3'h7;

	// Register offsets
	localparam logic [3:0] ADDR_GENERAL_OPTIONS = 4'h0;
	localparam logic [3:0] ADDR_X_TUNING_OUTPUT_TYPE = 4'h1;
	localparam logic [3:0] ADDR_Y_TUNING = 4'h2;
	localparam logic [3:0] ADDR_Z_TUNING = 4'h3;
	localparam logic [3:0] ADDR_XY_SENSITIVITY = 4'h4;
	localparam logic [3:0] ADDR_Z_SENSITIVITY_MODULATION = 4'h5;
	localparam logic [3:0] ADDR_COLUMN_PARITY = 4'h6;
	localparam logic [3:0] ADDR_DEVICE_STATUS = 4'h7;

	// Reset value of every stored register
	localparam logic [8:0] CFG_RESET = 9'h000;

	// Field positions
	localparam int CH_DISABLE_LSB = 1;
	localparam int OUTPUT_TYPE_MSB = 8;
	localparam int OUTPUT_TYPE_LSB = 7;
	localparam int PULLDOWN_BIT = 8;
	localparam int STATUS_PARITY_BIT = 0;

	// Output type codes
	localparam logic [1:0] OUT_DEMOD = 2'h0;
	localparam logic [1:0] OUT_CARRIER = 2'h1;

	// Serial read result framing
	localparam int DUMMY_BITS = 7;

endpackage
